/* cimc_params.svh */
// Constants for the CAN interrupt and operating-mode control block.
`ifndef CIMC_PARAMS_SVH
`define CIMC_PARAMS_SVH

// Register addresses seen by the serial command port.
`define CIMC_ADDR_STAT 8'h00
`define CIMC_ADDR_CTRL 8'h01
`define CIMC_ADDR_INTE 8'h02
`define CIMC_ADDR_INTF 8'h03

// Serial command opcodes.
`define CIMC_CMD_WRITE 8'h02
`define CIMC_CMD_READ 8'h03
`define CIMC_CMD_MODIFY 8'h05
`define CIMC_CMD_RESET 8'hC0

// Reset values and writable bits.
`define CIMC_CTRL_RST 8'hE7
`define CIMC_CTRL_WMASK 8'hF7
`define CIMC_INTE_RST 8'h00
`define CIMC_INTF_RST 8'h00

// Operating mode codes.
`define CIMC_MODE_NORMAL 3'h0
`define CIMC_MODE_SLEEP 3'h1
`define CIMC_MODE_LOOP 3'h2
`define CIMC_MODE_LISTEN 3'h3
`define CIMC_MODE_CONFIG 3'h4
`define CIMC_MODE_PWRUP 3'h7

// Interrupt code values, highest priority first.
`define CIMC_INTERRUPT_CODE_NONE 3'h0
`define CIMC_INTERRUPT_CODE_ERR 3'h1
`define CIMC_INTERRUPT_CODE_WAKE 3'h2
`define CIMC_INTERRUPT_CODE_TX0 3'h3
`define CIMC_INTERRUPT_CODE_TX1 3'h4
`define CIMC_INTERRUPT_CODE_TX2 3'h5
`define CIMC_INTERRUPT_CODE_RX0 3'h6
`define CIMC_INTERRUPT_CODE_RX1 3'h7

// Pin synchroniser reset value, ordered {si, cs_n, sck}.
`define CIMC_PIN_RST 3'h2

`endif

/* cimc_pkg.sv */
// Types shared by the CAN interrupt and operating-mode control block.
package cimc_pkg;

	// Eight event sources in register bit order.
	typedef struct packed {
		logic merr;
		logic wake;
		logic err;
		logic [2:0] tx;
		logic [1:0] rx;
	} cimc_irq_t;

	// Control register layout.
	typedef struct packed {
		logic [2:0] mode_req;
		logic abort;
		logic rsvd;
		logic clock_out_enable;
		logic [1:0] clock_out_prescale;
	} cimc_ctrl_t;

	// Status register layout.
	typedef struct packed {
		logic [2:0] mode;
		logic rsvd0;
		logic [2:0] interrupt_code;
		logic rsvd1;
	} cimc_stat_t;

	// Serial command parser states.
	typedef enum logic [6:0] {
		CIMC_ST_CMD = 7'h01,
		CIMC_ST_ADDR = 7'h02,
		CIMC_ST_WRITE = 7'h04,
		CIMC_ST_READ = 7'h08,
		CIMC_ST_MASK = 7'h10,
		CIMC_ST_MODIFY = 7'h20,
		CIMC_ST_IDLE = 7'h40
	} cimc_state_t;

endpackage

/* cimc_spi_slave.sv */
// Byte-level serial slave, mode 0, oversampled by the system clock.
`timescale 1ns/1ps

module cimc_spi_slave (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic [7:0] tx_byte,
	input wire logic tx_load,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic frame_start,
	output logic so,
	output logic so_oe
);

	logic sck_prev_q;
	logic cs_prev_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_in_q;
	logic [7:0] shift_out_q;
	logic rx_valid_q;
	logic [7:0] rx_byte_q;
	logic frame_start_q;
	logic so_oe_q;
	logic rise;
	logic fall;

	////////////////////////////////////////////////////////////////////////
	// Edge detection on the already synchronised pins.
	assign rise = sck & ~sck_prev_q & ~cs_n;
	assign fall = ~sck & sck_prev_q & ~cs_n;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
			frame_start_q <= 1'b0;
			so_oe_q <= 1'b0;
		end
		else
		begin
			sck_prev_q <= sck;
			cs_prev_q <= cs_n;
			frame_start_q <= cs_prev_q & ~cs_n;
			so_oe_q <= ~cs_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input shifter; a byte is complete on the eighth rising edge.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_q <= 3'h0;
			shift_in_q <= 8'h00;
			rx_valid_q <= 1'b0;
			rx_byte_q <= 8'h00;
		end
		else
		begin
			rx_valid_q <= rise & (bit_cnt_q == 3'h7);
			if (cs_n)
				bit_cnt_q <= 3'h0;
			else if (rise)
				bit_cnt_q <= bit_cnt_q + 3'h1;
			if (rise)
			begin
				shift_in_q <= {shift_in_q[6:0], si};
				rx_byte_q <= {shift_in_q[6:0], si};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output shifter; the falling edge at a byte boundary does not shift, so a load lands on the first bit.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_out_q <= 8'h00;
		else if (tx_load)
			shift_out_q <= tx_byte;
		else if (fall && bit_cnt_q != 3'h0)
			shift_out_q <= {shift_out_q[6:0], 1'b0};
	end

	assign rx_byte = rx_byte_q;
	assign rx_valid = rx_valid_q;
	assign frame_start = frame_start_q;
	assign so = shift_out_q[7];
	assign so_oe = so_oe_q;

endmodule

/* cimc_top.sv */
// Interrupt flags, interrupt code, operating mode and clock output control of a CAN controller.
`timescale 1ns/1ps
`include "cimc_params.svh"

module cimc_top (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	input wire logic [2:0] tx_done,
	input wire logic [1:0] rx_msg,
	input wire logic tx_err,
	input wire logic rx_err,
	input wire logic wake_evt,
	input wire logic [7:0] error_flag_register,
	output logic irq_n,
	output logic [1:0] rx_store,
	output logic [1:0] rx_discard,
	output logic abort_all_tx,
	output logic [2:0] current_mode,
	output logic timing_write_ok,
	output logic clock_out_pin
);

	logic [1:0] rst_pipe_q;
	logic rst_n;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic frame_start;
	cimc_pkg::cimc_state_t state_q;
	cimc_pkg::cimc_state_t state_d;
	logic [7:0] cmd_q;
	logic [7:0] addr_q;
	logic [7:0] mask_q;
	logic wr_en;
	logic [7:0] wr_mask;
	logic soft_rst;
	logic rd_now;
	logic [7:0] rd_addr;
	logic tx_load_q;
	logic [7:0] tx_byte_q;
	cimc_pkg::cimc_irq_t flags_q;
	cimc_pkg::cimc_irq_t enables_q;
	cimc_pkg::cimc_irq_t flag_set;
	cimc_pkg::cimc_irq_t pend;
	cimc_pkg::cimc_ctrl_t ctrl_q;
	cimc_pkg::cimc_stat_t stat;
	logic [2:0] mode_q;
	logic [2:0] applied_q;
	logic [2:0] target;
	logic wake_leave;
	logic [7:0] efr_prev_q;
	logic [2:0] interrupt_code_d;
	logic [2:0] interrupt_code_q;
	logic irq_n_q;
	logic [1:0] rx_store_q;
	logic [1:0] rx_discard_q;
	logic abort_q;
	logic cfg_q;
	logic [2:0] div_cnt_q;
	logic [2:0] div_lim;
	logic clk_out_q;
	logic clk_run;

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops; assertion stays asynchronous.
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rst_pipe_q <= 2'h0;
		else
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
	end
	assign rst_n = rst_pipe_q[1];

	// Serial pins cross into the clock domain through two flip-flops each.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_q <= `CIMC_PIN_RST;
			pin_sync_q <= `CIMC_PIN_RST;
		end
		else
		begin
			pin_meta_q <= {spi_si, spi_cs_n, spi_sck};
			pin_sync_q <= pin_meta_q;
		end
	end

	cimc_spi_slave u_spi (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.sck(pin_sync_q[0]),
		.cs_n(pin_sync_q[1]),
		.si(pin_sync_q[2]),
		.tx_byte(tx_byte_q),
		.tx_load(tx_load_q),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.frame_start(frame_start),
		.so(spi_so),
		.so_oe(spi_so_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// Command parser: opcode, address, then data, mask or read bytes.
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			cimc_pkg::CIMC_ST_CMD:
				if (rx_byte == `CIMC_CMD_WRITE || rx_byte == `CIMC_CMD_READ || rx_byte == `CIMC_CMD_MODIFY)
					state_d = cimc_pkg::CIMC_ST_ADDR;
				else
					state_d = cimc_pkg::CIMC_ST_IDLE;
			cimc_pkg::CIMC_ST_ADDR:
				if (cmd_q == `CIMC_CMD_WRITE)
					state_d = cimc_pkg::CIMC_ST_WRITE;
				else if (cmd_q == `CIMC_CMD_READ)
					state_d = cimc_pkg::CIMC_ST_READ;
				else
					state_d = cimc_pkg::CIMC_ST_MASK;
			cimc_pkg::CIMC_ST_WRITE: state_d = cimc_pkg::CIMC_ST_WRITE;
			cimc_pkg::CIMC_ST_READ: state_d = cimc_pkg::CIMC_ST_READ;
			cimc_pkg::CIMC_ST_MASK: state_d = cimc_pkg::CIMC_ST_MODIFY;
			cimc_pkg::CIMC_ST_MODIFY: state_d = cimc_pkg::CIMC_ST_IDLE;
			cimc_pkg::CIMC_ST_IDLE: state_d = cimc_pkg::CIMC_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= cimc_pkg::CIMC_ST_CMD;
			cmd_q <= 8'h00;
			addr_q <= 8'h00;
			mask_q <= 8'h00;
		end
		else if (frame_start)
			state_q <= cimc_pkg::CIMC_ST_CMD;
		else if (rx_valid)
		begin
			state_q <= state_d;
			if (state_q == cimc_pkg::CIMC_ST_CMD)
				cmd_q <= rx_byte;
			if (state_q == cimc_pkg::CIMC_ST_ADDR)
				addr_q <= rx_byte;
			else if (state_q == cimc_pkg::CIMC_ST_WRITE || state_q == cimc_pkg::CIMC_ST_READ)
				addr_q <= addr_q + 8'h01;
			if (state_q == cimc_pkg::CIMC_ST_MASK)
				mask_q <= rx_byte;
		end
	end

	// The modify command writes only the masked bits and leaves the rest alone.
	assign wr_en = rx_valid & (state_q == cimc_pkg::CIMC_ST_WRITE || state_q == cimc_pkg::CIMC_ST_MODIFY);
	assign wr_mask = (state_q == cimc_pkg::CIMC_ST_MODIFY) ? mask_q : 8'hFF;
	assign soft_rst = rx_valid & (state_q == cimc_pkg::CIMC_ST_CMD) & (rx_byte == `CIMC_CMD_RESET);
	assign rd_now = rx_valid & ((state_q == cimc_pkg::CIMC_ST_ADDR && cmd_q == `CIMC_CMD_READ)
		|| state_q == cimc_pkg::CIMC_ST_READ);
	assign rd_addr = (state_q == cimc_pkg::CIMC_ST_ADDR) ? rx_byte : addr_q + 8'h01;

	// Read mux; unmapped addresses return zero.
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`CIMC_ADDR_STAT: r = stat;
			`CIMC_ADDR_CTRL: r = ctrl_q;
			`CIMC_ADDR_INTE: r = enables_q;
			`CIMC_ADDR_INTF: r = flags_q;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// Read data is loaded into the output shifter two cycles after the byte completes.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_load_q <= 1'b0;
			tx_byte_q <= 8'h00;
		end
		else
		begin
			tx_load_q <= rd_now;
			if (rd_now)
				tx_byte_q <= reg_read(rd_addr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event sources; an error register bit counts only when it newly rises.
	assign wake_leave = (mode_q == `CIMC_MODE_SLEEP) & wake_evt;
	assign flag_set.merr = tx_err | rx_err;
	assign flag_set.wake = wake_leave;
	assign flag_set.err = |(error_flag_register & ~efr_prev_q);
	assign flag_set.tx = tx_done;
	assign flag_set.rx = rx_msg;

	// Flags: host writes merge under mask, and a same-cycle event wins over a clear.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_q <= `CIMC_INTF_RST;
			enables_q <= `CIMC_INTE_RST;
			efr_prev_q <= 8'h00;
		end
		else
		begin
			efr_prev_q <= error_flag_register;
			if (soft_rst)
				flags_q <= flag_set;
			else if (wr_en && addr_q == `CIMC_ADDR_INTF)
				flags_q <= (flags_q & ~wr_mask) | (rx_byte & wr_mask) | flag_set;
			else
				flags_q <= flags_q | flag_set;
			if (soft_rst)
				enables_q <= `CIMC_INTE_RST;
			else if (wr_en && addr_q == `CIMC_ADDR_INTE)
				enables_q <= (enables_q & ~wr_mask) | (rx_byte & wr_mask);
		end
	end

	// Receive lockout per buffer: store only while the buffer flag is clear.
	for (genvar i = 0; i < 2; i++)
	begin : g_rx
		always_ff @(posedge sys_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				rx_store_q[i] <= 1'b0;
				rx_discard_q[i] <= 1'b0;
			end
			else
			begin
				rx_store_q[i] <= rx_msg[i] & ~flags_q.rx[i];
				rx_discard_q[i] <= rx_msg[i] & flags_q.rx[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fixed-priority interrupt code over enabled pending sources.
	assign pend = flags_q & enables_q;
	always_comb
	begin
		interrupt_code_d = `CIMC_INTERRUPT_CODE_NONE;
		if (pend.err)
			interrupt_code_d = `CIMC_INTERRUPT_CODE_ERR;
		else if (pend.wake)
			interrupt_code_d = `CIMC_INTERRUPT_CODE_WAKE;
		else if (pend.tx[0])
			interrupt_code_d = `CIMC_INTERRUPT_CODE_TX0;
		else if (pend.tx[1])
			interrupt_code_d = `CIMC_INTERRUPT_CODE_TX1;
		else if (pend.tx[2])
			interrupt_code_d = `CIMC_INTERRUPT_CODE_TX2;
		else if (pend.rx[0])
			interrupt_code_d = `CIMC_INTERRUPT_CODE_RX0;
		else if (pend.rx[1])
			interrupt_code_d = `CIMC_INTERRUPT_CODE_RX1;
	end

	// The code is re-evaluated every cycle, so clearing the top flag exposes the next one.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			interrupt_code_q <= `CIMC_INTERRUPT_CODE_NONE;
			irq_n_q <= 1'b1;
		end
		else
		begin
			interrupt_code_q <= interrupt_code_d;
			irq_n_q <= ~|pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register; the reserved bit stays zero.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= `CIMC_CTRL_RST;
		else if (soft_rst)
			ctrl_q <= `CIMC_CTRL_RST;
		else if (wr_en && addr_q == `CIMC_ADDR_CTRL)
			ctrl_q <= (ctrl_q & ~(wr_mask & `CIMC_CTRL_WMASK)) | (rx_byte & wr_mask & `CIMC_CTRL_WMASK);
	end

	// Mode logic follows a changed request; the power-up code is read as configuration.
	assign target = (ctrl_q.mode_req == `CIMC_MODE_PWRUP) ? `CIMC_MODE_CONFIG : ctrl_q.mode_req;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= `CIMC_MODE_CONFIG;
			applied_q <= `CIMC_MODE_PWRUP;
		end
		else if (soft_rst)
		begin
			mode_q <= `CIMC_MODE_CONFIG;
			applied_q <= `CIMC_MODE_PWRUP;
		end
		else if (wake_leave)
			mode_q <= `CIMC_MODE_LISTEN;
		else if (ctrl_q.mode_req != applied_q)
		begin
			mode_q <= target;
			applied_q <= ctrl_q.mode_req;
		end
	end

	assign stat = {mode_q, 1'b0, interrupt_code_q, 1'b0};

	// Registered copies of abort and configuration qualifiers.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			abort_q <= 1'b0;
			cfg_q <= 1'b1;
		end
		else
		begin
			abort_q <= ctrl_q.abort;
			cfg_q <= (mode_q == `CIMC_MODE_CONFIG);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock output divider; stopped and held low when disabled or asleep.
	assign clk_run = ctrl_q.clock_out_enable & (mode_q != `CIMC_MODE_SLEEP);
	always_comb
	begin
		unique case (ctrl_q.clock_out_prescale)
			2'h0: div_lim = 3'h0;
			2'h1: div_lim = 3'h1;
			2'h2: div_lim = 3'h3;
			2'h3: div_lim = 3'h7;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_q <= 3'h0;
			clk_out_q <= 1'b0;
		end
		else if (!clk_run)
		begin
			div_cnt_q <= 3'h0;
			clk_out_q <= 1'b0;
		end
		else if (div_cnt_q >= div_lim)
		begin
			div_cnt_q <= 3'h0;
			clk_out_q <= ~clk_out_q;
		end
		else
			div_cnt_q <= div_cnt_q + 3'h1;
	end

	assign irq_n = irq_n_q;
	assign rx_store = rx_store_q;
	assign rx_discard = rx_discard_q;
	assign abort_all_tx = abort_q;
	assign current_mode = mode_q;
	assign timing_write_ok = cfg_q;
	assign clock_out_pin = clk_out_q;

	////////////////////////////////////////////////////////////////////////
	// Checks on flag, interrupt, mode and clock behaviour.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_cfg_write;
		wr_en && addr_q == `CIMC_ADDR_CTRL && wr_mask[7:5] == 3'h7 && rx_byte[7:5] == `CIMC_MODE_CONFIG;
	endsequence

	sequence s_cfg_reached;
		##[2:3] current_mode == `CIMC_MODE_CONFIG;
	endsequence

	flag_sets_a: assert property (tx_done[0] |=> flags_q.tx[0]) else $error("tx flag not set");
	irq_gate_a: assert property (##1 irq_n == !$past(|pend)) else $error("irq pin mismatch");
	merr_set_a: assert property ((tx_err || rx_err) |=> flags_q.merr) else $error("merr flag not set");
	wake_exit_a: assert property (wake_leave |=> flags_q.wake && current_mode == `CIMC_MODE_LISTEN)
		else $error("wake exit wrong");
	err_flag_a: assert property (|(error_flag_register & ~efr_prev_q) |=> flags_q.err)
		else $error("err flag not set");
	rx_lockout_a: assert property (rx_msg[0] && flags_q.rx[0] |=> rx_discard[0] && !rx_store[0])
		else $error("rx lockout broken");
	cfg_request_a: assert property (s_cfg_write |-> s_cfg_reached) else $error("config not entered");
	clk_sleep_a: assert property (current_mode == `CIMC_MODE_SLEEP |=> !clock_out_pin)
		else $error("clock out in sleep");
	interrupt_code_prio_a: assert property (pend.err |=> interrupt_code_q == `CIMC_INTERRUPT_CODE_ERR) else $error("interrupt_code priority");

endmodule

/* cimc_host_model.sv */
// Host controller model that reaches the block registers over the serial command port.
`timescale 1ns/1ps
`include "cimc_params.svh"

module cimc_host_model (
	input wire logic sys_clk,
	input wire logic spi_so,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si
);
	localparam int HALF = 10;

	// Serial clock stays low and the chip select high outside frames.
	initial
	begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end

	// Shifts one byte out MSB first and takes the reply bit at each rising serial clock edge.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			spi_si = tx[i];
			repeat (HALF) @(negedge sys_clk);
			spi_sck = 1'b1;
			rx[i] = spi_so;
			repeat (HALF) @(negedge sys_clk);
			spi_sck = 1'b0;
		end
	endtask

	// Runs one whole frame; the data line is turned over once the device is deselected.
	task automatic frame(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] b0,
		input logic [7:0] b1, input int nb, output logic [7:0] rd);
		logic [7:0] junk;
		@(negedge sys_clk);
		spi_cs_n = 1'b0;
		xfer(cmd, junk);
		xfer(adr, junk);
		xfer(b0, rd);
		if (nb > 1)
			xfer(b1, junk);
		repeat (HALF) @(negedge sys_clk);
		spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		repeat (HALF) @(negedge sys_clk);
	endtask

	// Full register write; the all-ones mode request is never sent to the control register.
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [7:0] junk;
		if (!(adr == `CIMC_ADDR_CTRL && d[7:5] == `CIMC_MODE_PWRUP))
			frame(`CIMC_CMD_WRITE, adr, d, 8'h00, 1, junk);
	endtask

	// Register read; the mode is judged from the status register, not the request field.
	task automatic rd(input logic [7:0] adr, output logic [7:0] d);
		frame(`CIMC_CMD_READ, adr, 8'h00, 8'h00, 1, d);
	endtask

	// Masked modify so that single flag or enable bits change without disturbing the rest.
	task automatic modify(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] d);
		logic [7:0] junk;
		frame(`CIMC_CMD_MODIFY, adr, m, d, 2, junk);
	endtask
endmodule

/* testbench.sv */
// Self-checking testbench for the CAN interrupt and operating-mode control block.
`timescale 1ns/1ps
`include "cimc_params.svh"

module testbench;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, wake_evt, tx_err, rx_err;
	logic irq_n, abort_all_tx, timing_write_ok, clock_out_pin;
	logic [2:0] tx_done, current_mode;
	logic [1:0] rx_msg, rx_store, rx_discard;
	logic [3:0] sd;
	logic [7:0] error_flag_register, d, en, fl;
	int miscompares = 0;
	int checks = 0;
	int seed = 19116;
	int cycles = 0;
	int r;

	cimc_top u_cimc_top (.sys_clk(sys_clk), .resetn(resetn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .tx_done(tx_done), .rx_msg(rx_msg),
		.tx_err(tx_err), .rx_err(rx_err), .wake_evt(wake_evt), .error_flag_register(error_flag_register),
		.irq_n(irq_n), .rx_store(rx_store), .rx_discard(rx_discard), .abort_all_tx(abort_all_tx),
		.current_mode(current_mode), .timing_write_ok(timing_write_ok), .clock_out_pin(clock_out_pin));
	cimc_host_model u_host (.sys_clk(sys_clk), .spi_so(spi_so), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si));

	// System clock of 25 MHz.
	always #20 sys_clk = ~sys_clk;

	// Cuts a hung run short well past the expected length.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// Compares a seen value with the expected one and counts both.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Raises event inputs for one cycle and returns the receive store and discard pulses.
	task automatic pulse(input logic [2:0] t, input logic [1:0] rx, input logic te, input logic re);
		@(negedge sys_clk);
		tx_done = t;
		rx_msg = rx;
		tx_err = te;
		rx_err = re;
		@(negedge sys_clk);
		sd = {rx_store, rx_discard};
		tx_done = 3'h0;
		rx_msg = 2'h0;
		tx_err = 1'b0;
		rx_err = 1'b0;
	endtask

	// Counts rising edges of the clock output over 64 system cycles.
	task automatic rises(output int n);
		logic prev;
		n = 0;
		prev = clock_out_pin;
		repeat (64)
		begin
			@(negedge sys_clk);
			if (clock_out_pin === 1'b1 && prev === 1'b0)
				n++;
			prev = clock_out_pin;
		end
	endtask

	// Expected status byte from the mode and the pending enabled sources, fixed priority.
	function automatic logic [7:0] stat(input logic [2:0] m, input logic [7:0] p);
		logic [2:0] c;
		c = p[5] ? `CIMC_INTERRUPT_CODE_ERR : p[6] ? `CIMC_INTERRUPT_CODE_WAKE : p[2] ? `CIMC_INTERRUPT_CODE_TX0 : p[3] ? `CIMC_INTERRUPT_CODE_TX1 :
			p[4] ? `CIMC_INTERRUPT_CODE_TX2 : p[0] ? `CIMC_INTERRUPT_CODE_RX0 : p[1] ? `CIMC_INTERRUPT_CODE_RX1 : `CIMC_INTERRUPT_CODE_NONE;
		return {m, 1'b0, c, 1'b0};
	endfunction

	// Main sequence.
	initial
	begin
		{tx_done, rx_msg, tx_err, rx_err, wake_evt} = '0;
		error_flag_register = 8'h00;
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (6) @(negedge sys_clk);
		u_host.rd(`CIMC_ADDR_CTRL, d);
		check("control", d, `CIMC_CTRL_RST);
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("status", d, 8'h80);
		check("timing_ok", 8'(timing_write_ok), 8'h01);
		u_host.rd(`CIMC_ADDR_INTF, d);
		check("flags", d, 8'h00);
		u_host.rd(8'h3C, d);
		check("unmapped", d, 8'h00);
		pulse(3'h0, 2'h0, 1'b0, 1'b1);
		u_host.rd(`CIMC_ADDR_INTF, d);
		check("rx_err_flag", d, 8'h80);
		u_host.wr(`CIMC_ADDR_INTF, 8'h00);
		pulse(3'h1, 2'h0, 1'b1, 1'b0);
		error_flag_register = 8'h10;
		u_host.rd(`CIMC_ADDR_INTF, d);
		check("flags_no_en", d, 8'hA4);
		check("irq_masked", 8'(irq_n), 8'h01);
		for (int i = 0; i < 6; i++)
		begin
			en = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
			fl = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : 8'($random(seed));
			u_host.wr(`CIMC_ADDR_INTE, en);
			u_host.wr(`CIMC_ADDR_INTF, fl);
			u_host.rd(`CIMC_ADDR_INTF, d);
			check("flags_rw", d, fl);
			u_host.rd(`CIMC_ADDR_STAT, d);
			check("interrupt_code", d, stat(`CIMC_MODE_CONFIG, fl & en));
			check("irq", 8'(irq_n), 8'(!(|(fl & en))));
		end
		u_host.wr(`CIMC_ADDR_INTE, 8'hFF);
		u_host.wr(`CIMC_ADDR_INTF, 8'h24);
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("interrupt_code_top", d, stat(`CIMC_MODE_CONFIG, 8'h24));
		u_host.modify(`CIMC_ADDR_INTF, 8'h20, 8'h00);
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("interrupt_code_next", d, stat(`CIMC_MODE_CONFIG, 8'h04));
		u_host.wr(`CIMC_ADDR_INTF, 8'h00);
		pulse(3'h0, 2'h1, 1'b0, 1'b0);
		check("rx_store", 8'(sd), 8'h04);
		pulse(3'h0, 2'h1, 1'b0, 1'b0);
		check("rx_discard", 8'(sd), 8'h01);
		u_host.modify(`CIMC_ADDR_INTF, 8'h01, 8'h00);
		pulse(3'h0, 2'h1, 1'b0, 1'b0);
		check("rx_again", 8'(sd), 8'h04);
		pulse(3'h2, 2'h0, 1'b0, 1'b0);
		pulse(3'h2, 2'h0, 1'b0, 1'b0);
		u_host.rd(`CIMC_ADDR_INTF, d);
		check("tx_reload", d, 8'h09);
		u_host.wr(`CIMC_ADDR_CTRL, 8'h07);
		check("normal", 8'(current_mode), 8'(`CIMC_MODE_NORMAL));
		check("timing_off", 8'(timing_write_ok), 8'h00);
		u_host.wr(`CIMC_ADDR_CTRL, 8'h27);
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("sleep_stat", d, stat(`CIMC_MODE_SLEEP, 8'h09));
		rises(r);
		check("sleep_clk", 8'(r), 8'h00);
		check("sleep_pin", 8'(clock_out_pin), 8'h00);
		@(negedge sys_clk);
		wake_evt = 1'b1;
		@(negedge sys_clk);
		wake_evt = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("woken", 8'(current_mode), 8'(`CIMC_MODE_LISTEN));
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("wake_stat", d, stat(`CIMC_MODE_LISTEN, 8'h49));
		u_host.wr(`CIMC_ADDR_CTRL, 8'h84);
		check("config", 8'(current_mode), 8'(`CIMC_MODE_CONFIG));
		check("timing_on", 8'(timing_write_ok), 8'h01);
		for (int p = 0; p < 4; p++)
		begin
			u_host.wr(`CIMC_ADDR_CTRL, 8'h84 | 8'(p));
			rises(r);
			check("prescale", 8'(r), 8'(64 >> (p + 1)));
		end
		u_host.wr(`CIMC_ADDR_CTRL, 8'h80);
		rises(r);
		check("clk_off", 8'({r[6:0], clock_out_pin}), 8'h00);
		u_host.wr(`CIMC_ADDR_CTRL, 8'h97);
		check("abort_on", 8'(abort_all_tx), 8'h01);
		u_host.rd(`CIMC_ADDR_CTRL, d);
		check("ctrl_rb", d, 8'h97);
		u_host.modify(`CIMC_ADDR_CTRL, 8'h10, 8'h00);
		check("abort_off", 8'(abort_all_tx), 8'h00);
		// Loopback request, then the serial reset command with the output enable watched inside and after the frame.
		u_host.wr(`CIMC_ADDR_CTRL, 8'h47);
		check("loopback", 8'(current_mode), 8'(`CIMC_MODE_LOOP));
		fork
			u_host.frame(`CIMC_CMD_RESET, 8'h00, 8'h00, 8'h00, 1, d);
			begin
				repeat (40) @(negedge sys_clk);
				check("so_oe_on", 8'(spi_so_oe), 8'h01);
			end
		join
		check("so_oe_off", 8'(spi_so_oe), 8'h00);
		check("soft_mode", 8'(current_mode), 8'(`CIMC_MODE_CONFIG));
		u_host.rd(`CIMC_ADDR_INTE, d);
		check("soft_inte", d, `CIMC_INTE_RST);
		// The status register ignores host writes.
		u_host.wr(`CIMC_ADDR_STAT, 8'hFF);
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("stat_ro", d, stat(`CIMC_MODE_CONFIG, 8'h00));
		// A second hardware reset in mid-run, taken from normal mode.
		u_host.wr(`CIMC_ADDR_CTRL, 8'h07);
		check("normal_again", 8'(current_mode), 8'(`CIMC_MODE_NORMAL));
		resetn = 1'b0;
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (6) @(negedge sys_clk);
		u_host.rd(`CIMC_ADDR_STAT, d);
		check("hard_stat", d, 8'h80);
		u_host.rd(`CIMC_ADDR_CTRL, d);
		check("hard_ctrl", d, `CIMC_CTRL_RST);
		wrap_up();
	end
endmodule
